//--- rtl/mmd_bus_if.sv
/*
  shared memory address and data bus between requester and decoder.
  assumes one clock; the decoder answers one cycle after a request, two cycles for sfr and peripheral slots.
*/
`timescale 1ns/1ns
`default_nettype none
`include "mmd_consts.svh"
interface mmd_bus_if;
  logic [`MMD_ADDR_W-1:0] memory_address_bus;
  logic [15:0]            memory_data_bus_wr;
  logic [15:0]            memory_data_bus_rd;
  logic                   req;
  logic                   wr;
  logic                   byte_access;
  logic                   fetch;
  logic                   ack;
  logic                   err;
  modport decoder (
    input  memory_address_bus, memory_data_bus_wr, req, wr, byte_access, fetch,
    output memory_data_bus_rd, ack, err
  );
  modport requester (
    output memory_address_bus, memory_data_bus_wr, req, wr, byte_access, fetch,
    input  memory_data_bus_rd, ack, err
  );
endinterface
`default_nettype wire

//--- rtl/mmd_consts.svh
/*
  constants for the memory map decoder: region bounds, widths, sizes.
  assumes inclusion by bare name from the package and both ends.
*/
// What this block does
// - code fetches use even addresses, whole words
// - byte and word data accesses, width flagged
// - address space spans 128 KB unified
// - program memory ends at 0ffffh
// - top 16 words hold vectors, 0fffeh highest
// - working memory starts at 0200h
// - 0100h to 01ffh go to word peripherals
// - requesters should use words on word peripherals
// - byte to word peripheral: even only, high zero
// - 010h to 0ffh go to byte peripherals
// - requesters should use bytes on byte peripherals
// - word read of byte peripheral: low valid
// - word write of byte peripheral: low only
// - lowest 16 bytes are bytewise registers
// - little-endian bytes, low byte at even address
// - words only at even addresses
// - program memory serves data reads in place
// - one address bus and one data bus; the interface splits data into memory_data_bus_wr and memory_data_bus_rd
`ifndef MMD_CONSTS_SVH
`define MMD_CONSTS_SVH
`define MMD_ADDR_W      17
`define MMD_SFR_END     17'h0000f
`define MMD_P8_START    17'h00010
`define MMD_P8_END      17'h000ff
`define MMD_P16_START   17'h00100
`define MMD_P16_END     17'h001ff
`define MMD_RAM_START   17'h00200
`define MMD_ROM_END     17'h0ffff
`define MMD_VEC_START   17'h0ffe0
`define MMD_RAM_BYTES   1024
`define MMD_ROM_BYTES   4096
`endif

//--- rtl/mmd_decoder.sv
/*
  address decoder and width adapter: routes each mapped access to sfr, byte
  peripheral, word peripheral, ram or program memory; holds ram and
  program memory arrays itself; peripheral slots appear on user ports.
  assumes requests come from the requester end, one at a time.
*/
`timescale 1ns/1ns
`default_nettype none
`include "mmd_consts.svh"
module mmd_decoder #(
  parameter int RAM_BYTES = `MMD_RAM_BYTES,
  parameter int ROM_BYTES = `MMD_ROM_BYTES
) (
  input  wire logic        mclk_i,
  input  wire logic        rstn_i,
  mmd_bus_if.decoder       bus,
  input  wire logic        rom_we_i,
  input  wire logic [15:0] rom_waddr_i,
  input  wire logic [7:0]  rom_wdata_i,
  output logic             per_sel_o,
  output logic             per_wide_o,
  output logic             per_wr_o,
  output logic [8:0]       per_addr_o,
  output logic [15:0]      per_wdata_o,
  output logic [1:0]       per_be_o,
  input  wire logic [15:0] per_rdata_i
);
  localparam logic [16:0] ROM_START = 17'(`MMD_ROM_END + 1 - ROM_BYTES);
  localparam logic [16:0] RAM_END   = 17'(`MMD_RAM_START + RAM_BYTES - 1);
  localparam int RAW = $clog2(RAM_BYTES);
  localparam int ROW = $clog2(ROM_BYTES);

  logic [7:0] ram_mem [RAM_BYTES];
  logic [7:0] rom_mem [ROM_BYTES];

  // region decode, single address space
  function automatic mmd_pkg::mmd_region_type region_of(input logic [16:0] a);
    if (a <= `MMD_SFR_END) begin
      return mmd_pkg::MMD_REG_SFR;
    end else if (a <= `MMD_P8_END) begin
      return mmd_pkg::MMD_REG_P8;
    end else if (a <= `MMD_P16_END) begin
      return mmd_pkg::MMD_REG_P16;
    end else if (a <= RAM_END) begin
      return mmd_pkg::MMD_REG_RAM;
    end else if (a >= ROM_START && a <= `MMD_ROM_END) begin
      return mmd_pkg::MMD_REG_ROM;
    end else begin
      return mmd_pkg::MMD_REG_NONE;
    end
  endfunction

  // refusals: odd words, byte or odd fetches, odd bytes to word slots, words to sfr
  function automatic logic refused(input mmd_pkg::mmd_region_type r,
                                   input logic                    byte_w,
                                   input logic                    fch,
                                   input logic                    odd_a);
    logic bad_v;
    bad_v = (!byte_w || fch) && odd_a;
    if (fch && byte_w) begin
      bad_v = 1'b1;
    end
    if (r == mmd_pkg::MMD_REG_P16 && byte_w && odd_a) begin
      bad_v = 1'b1;
    end
    if (r == mmd_pkg::MMD_REG_SFR && !byte_w) begin
      bad_v = 1'b1;
    end
    return bad_v;
  endfunction

  // byte reads come back in the low lane with the upper lane zero
  function automatic logic [15:0] lane_pick(input logic       byte_w,
                                            input logic       hi_sel,
                                            input logic [7:0] lo_v,
                                            input logic [7:0] hi_v);
    if (byte_w) begin
      return {8'h00, hi_sel ? hi_v : lo_v};
    end else begin
      return {hi_v, lo_v};
    end
  endfunction

  typedef struct packed {
    logic        ack;
    logic        err;
    logic [15:0] rdata;
    logic        per_sel;
    logic        per_wide;
    logic        per_wr;
    logic [8:0]  per_addr;
    logic [15:0] per_wdata;
    logic [1:0]  per_be;
    logic        per_pend;
    logic        per_p16;
    logic        per_hi;
  } mmd_dec_state_type;

  mmd_dec_state_type st;
  mmd_dec_state_type next_st;
  mmd_pkg::mmd_region_type reg_now;
  logic [16:0] a0;
  logic        odd;
  logic        bad;
  logic [7:0]  lo_b;
  logic [7:0]  hi_b;

  assign reg_now = region_of(bus.memory_address_bus);
  assign a0      = {bus.memory_address_bus[16:1], 1'b0};
  assign odd     = bus.memory_address_bus[0];

  always_comb begin
    next_st          = st;
    next_st.ack      = 1'b0;
    next_st.err      = 1'b0;
    next_st.per_sel  = 1'b0;
    next_st.per_pend = 1'b0;
    bad              = 1'b0;
    lo_b             = 8'h00;
    hi_b             = 8'h00;
    if (st.per_pend) begin
      // peripheral read data is taken in the strobe cycle; the bus ack follows on the next cycle
      next_st.ack = 1'b1;
      if (st.per_hi) begin
        next_st.rdata = {8'h00, per_rdata_i[15:8]};
      end else if (st.per_p16 || st.per_wide) begin
        next_st.rdata = st.per_p16 && !st.per_wide ? {8'h00, per_rdata_i[7:0]} : per_rdata_i;
      end else begin
        next_st.rdata = {8'h00, per_rdata_i[7:0]};
      end
    end else if (bus.req && !st.ack) begin
      bad           = refused(reg_now, bus.byte_access, bus.fetch, odd);
      next_st.rdata = 16'h0000;
      if (bad) begin
        next_st.ack = 1'b1;
        next_st.err = 1'b1;
      end else begin
        case (reg_now)
          mmd_pkg::MMD_REG_SFR, mmd_pkg::MMD_REG_P8, mmd_pkg::MMD_REG_P16: begin
            next_st.per_sel   = 1'b1;
            next_st.per_pend  = 1'b1;
            next_st.per_p16   = (reg_now == mmd_pkg::MMD_REG_P16);
            next_st.per_wide  = !bus.byte_access;
            next_st.per_wr    = bus.wr;
            next_st.per_addr  = bus.memory_address_bus[8:0];
            next_st.per_hi    = bus.byte_access && odd;
            next_st.per_wdata = bus.byte_access ? {bus.memory_data_bus_wr[7:0], bus.memory_data_bus_wr[7:0]}
                                                : bus.memory_data_bus_wr;
            if (reg_now == mmd_pkg::MMD_REG_P16) begin
              next_st.per_be = bus.byte_access ? 2'h1 : 2'h3;
            end else if (bus.byte_access) begin
              next_st.per_be = odd ? 2'h2 : 2'h1;
            end else begin
              next_st.per_be = 2'h1;
            end
          end
          mmd_pkg::MMD_REG_RAM: begin
            next_st.ack = 1'b1;
            lo_b = ram_mem[RAW'(a0 - `MMD_RAM_START)];
            hi_b = ram_mem[RAW'(a0 - `MMD_RAM_START + 17'h00001)];
            next_st.rdata = lane_pick(bus.byte_access, odd, lo_b, hi_b);
          end
          mmd_pkg::MMD_REG_ROM: begin
            next_st.ack = 1'b1;
            lo_b = rom_mem[ROW'(a0 - ROM_START)];
            hi_b = rom_mem[ROW'(a0 - ROM_START + 17'h00001)];
            if (!bus.wr) begin
              next_st.rdata = lane_pick(bus.byte_access, odd, lo_b, hi_b);
            end
          end
          default: begin
            next_st.ack = 1'b1;
          end
        endcase
      end
    end
  end

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // array writes: ram from bus, program memory from loader port
  always_ff @(posedge mclk_i) begin
    if (bus.req && !st.ack && !st.per_pend && bus.wr && reg_now == mmd_pkg::MMD_REG_RAM
        && !refused(reg_now, bus.byte_access, bus.fetch, odd) && !bus.fetch) begin
      if (bus.byte_access) begin
        ram_mem[RAW'(bus.memory_address_bus - `MMD_RAM_START)] <= bus.memory_data_bus_wr[7:0];
      end else begin
        ram_mem[RAW'(a0 - `MMD_RAM_START)]               <= bus.memory_data_bus_wr[7:0];
        ram_mem[RAW'(a0 - `MMD_RAM_START + 17'h00001)] <= bus.memory_data_bus_wr[15:8];
      end
    end
    if (rom_we_i) begin
      rom_mem[ROW'(rom_waddr_i)] <= rom_wdata_i;
    end
  end

  assign bus.ack            = st.ack;
  assign bus.err            = st.err;
  assign bus.memory_data_bus_rd = st.rdata;
  assign per_sel_o   = st.per_sel;
  assign per_wide_o  = st.per_wide;
  assign per_wr_o    = st.per_wr;
  assign per_addr_o  = st.per_addr;
  assign per_wdata_o = st.per_wdata;
  assign per_be_o    = st.per_be;
endmodule
`default_nettype wire

//--- rtl/mmd_pkg.sv
/*
  types shared by the decoder and the requester end.
  assumes the constants header is on the include path.
*/
`include "mmd_consts.svh"
package mmd_pkg;
  typedef enum logic [5:0] {
    MMD_REG_NONE = 6'h01,
    MMD_REG_SFR  = 6'h02,
    MMD_REG_P8   = 6'h04,
    MMD_REG_P16  = 6'h08,
    MMD_REG_RAM  = 6'h10,
    MMD_REG_ROM  = 6'h20
  } mmd_region_type;
  typedef enum logic [2:0] {
    MMD_ST_IDLE = 3'h1,
    MMD_ST_REQ  = 3'h2,
    MMD_ST_DONE = 3'h4
  } mmd_state_type;
endpackage

//--- rtl/mmd_requester.sv
/*
  requester end: takes one access from user ports, drives the shared
  bus, waits for the decoder answer and returns the read data.
  assumes the decoder answers within a few cycles.
*/
`timescale 1ns/1ns
`default_nettype none
`include "mmd_consts.svh"
module mmd_requester (
  input  wire logic        mclk_i,
  input  wire logic        rstn_i,
  mmd_bus_if.requester     bus,
  input  wire logic        start_i,
  input  wire logic        wr_i,
  input  wire logic        byte_i,
  input  wire logic        fetch_i,
  input  wire logic [16:0] addr_i,
  input  wire logic [15:0] wdata_i,
  output logic             busy_o,
  output logic             done_o,
  output logic             err_o,
  output logic [15:0]      rdata_o
);
  typedef struct packed {
    mmd_pkg::mmd_state_type fsm;
    logic [16:0] addr;
    logic [15:0] wdata;
    logic        wr;
    logic        byte_access;
    logic        fetch;
    logic        done;
    logic        err;
    logic [15:0] rdata;
    logic        busy;
  } mmd_req_state_type;

  mmd_req_state_type st;
  mmd_req_state_type next_st;

  always_comb begin
    next_st      = st;
    next_st.done = 1'b0;
    case (st.fsm)
      mmd_pkg::MMD_ST_IDLE: begin
        if (start_i) begin
          next_st.fsm         = mmd_pkg::MMD_ST_REQ;
          next_st.addr        = addr_i;
          next_st.wdata       = wdata_i;
          next_st.wr          = wr_i && !fetch_i;
          next_st.byte_access = byte_i && !fetch_i;
          next_st.fetch       = fetch_i;
        end
      end
      mmd_pkg::MMD_ST_REQ: begin
        if (bus.ack) begin
          next_st.fsm   = mmd_pkg::MMD_ST_DONE;
          next_st.done  = 1'b1;
          next_st.err   = bus.err;
          next_st.rdata = bus.memory_data_bus_rd;
        end
      end
      mmd_pkg::MMD_ST_DONE: begin
        next_st.fsm = mmd_pkg::MMD_ST_IDLE;
      end
      default: begin
        next_st.fsm = mmd_pkg::MMD_ST_IDLE;
      end
    endcase
    next_st.busy = (next_st.fsm != mmd_pkg::MMD_ST_IDLE);
  end

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st     <= '0;
      st.fsm <= mmd_pkg::MMD_ST_IDLE;
    end else begin
      st <= next_st;
    end
  end

  assign bus.req                = (st.fsm == mmd_pkg::MMD_ST_REQ);
  assign bus.memory_address_bus = st.addr;
  assign bus.memory_data_bus_wr = st.wdata;
  assign bus.wr                 = st.wr;
  assign bus.byte_access        = st.byte_access;
  assign bus.fetch              = st.fetch;
  assign busy_o  = st.busy;
  assign done_o  = st.done;
  assign err_o   = st.err;
  assign rdata_o = st.rdata;
endmodule
`default_nettype wire

//--- test/mmd_bus_properties.sv
/*
  checker on the shared bus between requester and decoder.
  assumes one clock and the decoder's default region sizes.
*/
`timescale 1ns/1ns
`default_nettype none
`include "mmd_consts.svh"
module mmd_bus_properties (
  input wire logic                   mclk_i,
  input wire logic                   rstn_i,
  input wire logic [`MMD_ADDR_W-1:0] memory_address_bus,
  input wire logic [15:0]            memory_data_bus_rd,
  input wire logic                   req,
  input wire logic                   wr,
  input wire logic                   byte_access,
  input wire logic                   fetch,
  input wire logic                   ack,
  input wire logic                   err
);
  logic [16:0] a;
  logic        odd;
  logic        bad;
  logic        ram;
  logic        gap;
  assign a   = memory_address_bus;
  assign odd = a[0] && !byte_access;
  assign bad = odd || (fetch && (byte_access || a[0])) || (a <= `MMD_SFR_END && !byte_access)
               || (a[16:8] == 9'h001 && a[0]);
  assign ram = a >= `MMD_RAM_START && a < `MMD_RAM_START + `MMD_RAM_BYTES;
  assign gap = a[16] || (a >= `MMD_RAM_START + `MMD_RAM_BYTES && a < `MMD_ROM_END + 1 - `MMD_ROM_BYTES);
  default clocking @(posedge mclk_i);
  endclocking
  default disable iff (!rstn_i);
  sequence s_take;
    $rose(req);
  endsequence
  sequence s_slow;
    !ack ##1 (ack && !err);
  endsequence
  property p_refused(c);
    s_take ##0 c |=> ack && err;
  endproperty
  chk_odd_word: assert property (p_refused(odd))
    else $error("odd word not refused");
  chk_fetch_form: assert property (p_refused(fetch && (byte_access || a[0])))
    else $error("bad fetch not refused");
  chk_sfr_bytes: assert property (p_refused(a <= `MMD_SFR_END && !byte_access))
    else $error("word to sfr not refused");
  chk_p16_odd: assert property (p_refused(byte_access && a[16:8] == 9'h001 && a[0]))
    else $error("odd byte to word slot not refused");
  chk_ram_answer: assert property (s_take ##0 (ram && !bad) |=> ack && !err)
    else $error("ram access not answered");
  chk_per_answer: assert property (s_take ##0 (a >= `MMD_P8_START && a <= `MMD_P16_END && !bad) |=> s_slow)
    else $error("peripheral access not answered in two");
  chk_gap_zero: assert property (s_take ##0 (gap && !bad && !wr) |=> ack && !err && memory_data_bus_rd == 16'h0000)
    else $error("unmapped read not zero");
  chk_byte_upper: assert property (ack && !err && !wr && byte_access |-> memory_data_bus_rd[15:8] == 8'h00)
    else $error("byte read upper not zero");
  chk_req_hold: assert property (req && !ack |=> req && $stable(memory_address_bus))
    else $error("request dropped before answer");
  chk_one_answer: assert property (ack |=> !ack && !req)
    else $error("answer not single");
  chk_err_ack: assert property (err |-> ack)
    else $error("err without ack");
endmodule
`default_nettype wire

//--- test/test_memory_map_address_decoder.sv
/*
  testbench: requester and decoder joined by the shared bus, checker beside it.
  assumes default sizes: ram 0200h-05ffh, program memory 0f000h-0ffffh.
*/
`timescale 1ns/1ns
`default_nettype none
module test_memory_map_address_decoder;
  logic        mclk_i = 1'b0;
  logic        rstn_i = 1'b0;
  logic        start_i = 1'b0;
  logic        wr_i = 1'b0;
  logic        byte_i = 1'b0;
  logic        fetch_i = 1'b0;
  logic [16:0] addr_i = 17'h00000;
  logic [15:0] wdata_i = 16'h0000;
  logic        rom_we_i = 1'b0;
  logic [15:0] rom_waddr_i = 16'h0000;
  logic [7:0]  rom_wdata_i = 8'h00;
  logic [15:0] per_rdata_i = 16'h0000;
  logic        done_o, err_o, per_sel_o, busy_o, per_wide_o, per_wr_o, pwide, pwr;
  logic [15:0] rdata_o, per_wdata_o, pwd;
  logic [8:0]  per_addr_o, pad;
  logic [1:0]  per_be_o, pbe;
  int          fails = 0;
  int          compares = 0;
  mmd_bus_if bus ();
  mmd_requester i_mmd_requester (.mclk_i(mclk_i), .rstn_i(rstn_i), .bus(bus), .start_i(start_i),
    .wr_i(wr_i), .byte_i(byte_i), .fetch_i(fetch_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .busy_o(busy_o), .done_o(done_o), .err_o(err_o), .rdata_o(rdata_o));
  mmd_decoder i_mmd_decoder (.mclk_i(mclk_i), .rstn_i(rstn_i), .bus(bus), .rom_we_i(rom_we_i),
    .rom_waddr_i(rom_waddr_i), .rom_wdata_i(rom_wdata_i), .per_sel_o(per_sel_o), .per_wide_o(per_wide_o),
    .per_wr_o(per_wr_o), .per_addr_o(per_addr_o), .per_wdata_o(per_wdata_o), .per_be_o(per_be_o),
    .per_rdata_i(per_rdata_i));
  mmd_bus_properties i_mmd_bus_properties (.mclk_i(mclk_i), .rstn_i(rstn_i),
    .memory_address_bus(bus.memory_address_bus), .memory_data_bus_rd(bus.memory_data_bus_rd),
    .req(bus.req), .wr(bus.wr), .byte_access(bus.byte_access), .fetch(bus.fetch), .ack(bus.ack),
    .err(bus.err));
  initial begin
    forever #20 mclk_i = ~mclk_i;
  end
  always @(posedge mclk_i) begin
    if (per_sel_o === 1'b1) begin
      {pwide, pwr, pbe, pwd, pad} <= {per_wide_o, per_wr_o, per_be_o, per_wdata_o, per_addr_o};
    end
  end
  task automatic cmp16(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cmp1(input logic got, input logic exp);
    cmp16({15'h0000, got}, {15'h0000, exp});
  endtask
  task automatic xfer(input logic w, b, f, input logic [16:0] ad, input logic [15:0] wd, ex, input logic e);
    int n = 0;
    repeat (3) @(posedge mclk_i);
    start_i <= 1'b1;
    {wr_i, byte_i, fetch_i, addr_i, wdata_i} <= {w, b, f, ad, wd};
    @(posedge mclk_i);
    start_i <= 1'b0;
    while (done_o !== 1'b1 && n < 20) begin
      @(negedge mclk_i);
      n++;
    end
    cmp1(done_o, 1'b1);
    cmp1(busy_o, 1'b1);
    cmp1(err_o, e);
    if (!w && !e) cmp16(rdata_o, ex);
  endtask
  task automatic t_ram;
    xfer(1'b1, 1'b0, 1'b0, 17'h00200, 16'h1234, 16'h0000, 1'b0);
    xfer(1'b1, 1'b1, 1'b0, 17'h00202, 16'h00ef, 16'h0000, 1'b0);
    xfer(1'b1, 1'b1, 1'b0, 17'h00203, 16'h00cd, 16'h0000, 1'b0);
    xfer(1'b0, 1'b1, 1'b0, 17'h00201, 16'h0000, 16'h0012, 1'b0);
    xfer(1'b0, 1'b0, 1'b0, 17'h00202, 16'h0000, 16'hcdef, 1'b0);
    xfer(1'b0, 1'b0, 1'b1, 17'h00200, 16'h0000, 16'h1234, 1'b0);
    xfer(1'b1, 1'b0, 1'b0, 17'h005fe, 16'h8421, 16'h0000, 1'b0);
    xfer(1'b0, 1'b0, 1'b0, 17'h005fe, 16'h0000, 16'h8421, 1'b0);
    xfer(1'b1, 1'b0, 1'b0, 17'h00600, 16'h7777, 16'h0000, 1'b0);
    xfer(1'b0, 1'b0, 1'b0, 17'h00600, 16'h0000, 16'h0000, 1'b0);
    $display("ram test done");
  endtask
  task automatic rom_ld(input logic [15:0] o, input logic [7:0] d);
    @(posedge mclk_i);
    rom_we_i <= 1'b1;
    {rom_waddr_i, rom_wdata_i} <= {o, d};
    @(posedge mclk_i);
    rom_we_i <= 1'b0;
  endtask
  task automatic t_rom;
    rom_ld(16'h0ffe, 8'hcd);
    rom_ld(16'h0fff, 8'hab);
    rom_ld(16'h0000, 8'h3c);
    rom_ld(16'h0001, 8'h5a);
    xfer(1'b0, 1'b0, 1'b1, 17'h0fffe, 16'h0000, 16'habcd, 1'b0);
    xfer(1'b0, 1'b1, 1'b0, 17'h0ffff, 16'h0000, 16'h00ab, 1'b0);
    xfer(1'b1, 1'b0, 1'b0, 17'h0fffe, 16'h0000, 16'h0000, 1'b0);
    xfer(1'b0, 1'b0, 1'b0, 17'h0fffe, 16'h0000, 16'habcd, 1'b0);
    xfer(1'b0, 1'b0, 1'b0, 17'h0f000, 16'h0000, 16'h5a3c, 1'b0);
    xfer(1'b0, 1'b0, 1'b0, 17'h0effe, 16'h0000, 16'h0000, 1'b0);
    xfer(1'b0, 1'b0, 1'b0, 17'h10000, 16'h0000, 16'h0000, 1'b0);
    $display("rom test done");
  endtask
  task automatic t_refuse;
    xfer(1'b1, 1'b0, 1'b0, 17'h00201, 16'hffff, 16'h0000, 1'b1);
    xfer(1'b0, 1'b0, 1'b0, 17'h00200, 16'h0000, 16'h1234, 1'b0);
    xfer(1'b0, 1'b0, 1'b1, 17'h00201, 16'h0000, 16'h0000, 1'b1);
    xfer(1'b0, 1'b1, 1'b0, 17'h00101, 16'h0000, 16'h0000, 1'b1);
    xfer(1'b0, 1'b0, 1'b0, 17'h00004, 16'h0000, 16'h0000, 1'b1);
    $display("refusal test done");
  endtask
  task automatic t_per;
    per_rdata_i <= 16'hbeef;
    xfer(1'b0, 1'b0, 1'b0, 17'h00100, 16'h0000, 16'hbeef, 1'b0);
    xfer(1'b0, 1'b1, 1'b0, 17'h00100, 16'h0000, 16'h00ef, 1'b0);
    xfer(1'b0, 1'b1, 1'b0, 17'h000ff, 16'h0000, 16'h00be, 1'b0);
    xfer(1'b0, 1'b0, 1'b0, 17'h00010, 16'h0000, 16'hbeef, 1'b0);
    cmp16(rdata_o & 16'h00ff, 16'h00ef);
    xfer(1'b1, 1'b0, 1'b0, 17'h00010, 16'ha5c3, 16'h0000, 1'b0);
    cmp16({6'h00, pbe, pwd[7:0]}, 16'h01c3);
    cmp16({7'h00, pad}, 16'h0010);
    cmp1(pwr, 1'b1);
    cmp1(pwide, 1'b1);
    xfer(1'b1, 1'b1, 1'b0, 17'h00003, 16'h0055, 16'h0000, 1'b0);
    cmp16({6'h00, pbe, pwd[7:0]}, 16'h0255);
    cmp1(pwide, 1'b0);
    xfer(1'b1, 1'b0, 1'b0, 17'h001fe, 16'h1357, 16'h0000, 1'b0);
    cmp16({pbe, pwd[13:0]}, 16'hd357);
    $display("peripheral test done");
  endtask
  task automatic close_out;
    $display("compares=%0d fails=%0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    #(40 * 3000);
    fails++;
    close_out();
  end
  initial begin
    repeat (2) @(posedge mclk_i);
    rstn_i <= 1'b1;
    t_ram();
    t_rom();
    t_refuse();
    t_per();
    close_out();
  end
endmodule
`default_nettype wire
